// [include/aebc_pkg.sv]
// Functional notes
// - latch strobe runs during internal code execution
// - suppress bit stops strobe except external cycles
// - suppressed strobe pin released, weakly pulled high
// - bit 7 set disables port weak pull-ups
// - read/write strobes last 6 or 30 clocks
// - reset 0X0X1100, whole-byte writes only
package aebc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  AUX_IDX        = 8'h8e;
    localparam logic [7:0]  STAT_IDX       = 8'h8f;
    localparam int          AXI_ADDR_W     = 12;
    localparam logic [11:0] AUX_ADDR       = {2'h0, AUX_IDX, 2'h0};
    localparam logic [11:0] STAT_ADDR      = {2'h0, STAT_IDX, 2'h0};

    // control field positions
    localparam int          BIT_SUPPRESS   = 0;
    localparam int          BIT_OFFCHIP    = 1;
    localparam int          BIT_SIZE_LO    = 2;
    localparam int          BIT_SIZE_HI    = 3;
    localparam int          BIT_STRETCH    = 5;
    localparam int          BIT_PULLUP_DIS = 7;

    // reset value and writable bits; reserved 6 and 4 are not stored
    localparam logic [7:0]  AUX_RESET      = 8'h0c;
    localparam logic [7:0]  AUX_WMASK      = 8'haf;

    // phase lengths in core clock periods
    localparam logic [4:0]  ALE_CYC        = 5'h02;
    localparam logic [4:0]  STROBE_SHORT   = 5'h06;
    localparam logic [4:0]  STROBE_LONG    = 5'h1e;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        KIND_INTERNAL = 3'b000,
        KIND_FETCH    = 3'b001,
        KIND_CODE     = 3'b010,
        KIND_XREAD    = 3'b011,
        KIND_XWRITE   = 3'b100
    } aebc_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ALE    = 2'b01,
        ST_STROBE = 2'b10,
        ST_DONE   = 2'b11
    } aebc_state_t;

    // expanded ram size in bytes for a size code
    function automatic logic [10:0] xramSize(input logic [1:0] code);
        return {1'b0, code, 8'h00} + 11'h100;
    endfunction

endpackage

// [logic/aebc_phase_timer.sv]
module aebc_phase_timer #(
    parameter int W = 5
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // status
    output logic              last
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = count;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // high in the final cycle of a loaded phase
    assign last = (cnt_ff == W'(1));

endmodule // aebc_phase_timer

// [logic/aebc_ram_router.sv]
module aebc_ram_router (
    // data move target
    input  wire logic [15:0] addr,
    // configuration
    input  wire logic [1:0]  sizeCode,
    input  wire logic        offchipSel,
    // result
    output logic [10:0]      sizeBytes,
    output logic             onchip
);

    always_comb begin
        sizeBytes = aebc_pkg::xramSize(sizeCode);
        // addresses beyond the on-chip size still go out on the bus
        onchip = !offchipSel && (addr < {5'h00, sizeBytes});
    end

endmodule // aebc_ram_router

// [logic/aebc_top.sv]
module aebc_top (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // axi4-lite write address
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // core bus-cycle request
    input  wire logic                     reqValid,
    input  wire aebc_pkg::aebc_kind_t     reqKind,
    input  wire logic [15:0]              reqAddr,
    output logic                          reqReady,
    output logic                          doneValid,
    output logic                          doneOnchip,
    // external bus pins
    output logic                          aleOut,
    output logic                          aleOeN,
    output logic                          alePullupEn,
    output logic                          rdStrobeN,
    output logic                          wrStrobeN,
    // configuration to the chip
    output logic                          portPullupEn,
    output logic [10:0]                   xramBytes,
    output logic                          offchipRamSel
);

    function automatic logic regHit(input logic [11:0] a, input logic [11:0] base);
        return a[11:2] == base[11:2];
    endfunction

    // register bus state
    logic                  awHeld_ff;
    logic                  nxt_awHeld;
    logic [11:0]           awAddr_ff;
    logic [11:0]           nxt_awAddr;
    logic                  wHeld_ff;
    logic                  nxt_wHeld;
    logic [7:0]            wData_ff;
    logic [7:0]            nxt_wData;
    logic                  wLow_ff;
    logic                  nxt_wLow;
    logic                  bValid_ff;
    logic                  nxt_bValid;
    logic [1:0]            bResp_ff;
    logic [1:0]            nxt_bResp;
    logic                  rValid_ff;
    logic                  nxt_rValid;
    logic [31:0]           rData_ff;
    logic [31:0]           nxt_rData;
    logic [1:0]            rResp_ff;
    logic [1:0]            nxt_rResp;
    logic [7:0]            aux_ff;
    logic [7:0]            nxt_aux;

    // sequencer state
    aebc_pkg::aebc_state_t state_ff;
    aebc_pkg::aebc_state_t nxt_state;
    aebc_pkg::aebc_kind_t  kind_ff;
    aebc_pkg::aebc_kind_t  nxt_kind;
    logic                  onchip_ff;
    logic                  nxt_onchip;
    logic                  tmrLoad;
    logic [4:0]            tmrCount;
    logic                  tmrLast;
    logic                  routeOnchip;

    // pin state
    logic                  ale_ff;
    logic                  nxt_ale;
    logic                  aleOeN_ff;
    logic                  nxt_aleOeN;
    logic                  rdN_ff;
    logic                  nxt_rdN;
    logic                  wrN_ff;
    logic                  nxt_wrN;

    logic                  suppress;
    logic                  isDataMove;
    logic [31:0]           statusWord;

    assign suppress   = aux_ff[aebc_pkg::BIT_SUPPRESS];
    assign isDataMove = (reqKind == aebc_pkg::KIND_XREAD) || (reqKind == aebc_pkg::KIND_XWRITE);

    aebc_ram_router i_aebc_ram_router (
        .addr       (reqAddr),
        .sizeCode   (aux_ff[aebc_pkg::BIT_SIZE_HI:aebc_pkg::BIT_SIZE_LO]),
        .offchipSel (aux_ff[aebc_pkg::BIT_OFFCHIP]),
        .sizeBytes  (xramBytes),
        .onchip     (routeOnchip)
    );

    aebc_phase_timer #(
        .W (5)
    ) i_aebc_phase_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (tmrLoad),
        .count    (tmrCount),
        .last     (tmrLast)
    );

    // register bus: address and data are taken independently, write fires once both are held
    always_comb begin
        nxt_awHeld = awHeld_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wHeld  = wHeld_ff;
        nxt_wData  = wData_ff;
        nxt_wLow   = wLow_ff;
        nxt_bValid = bValid_ff;
        nxt_bResp  = bResp_ff;
        nxt_aux    = aux_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_awHeld = 1'b1;
            nxt_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_wHeld = 1'b1;
            nxt_wData = s_axi_wdata[7:0];
            nxt_wLow  = s_axi_wstrb[0];
        end
        if (awHeld_ff && wHeld_ff) begin
            nxt_awHeld = 1'b0;
            nxt_wHeld  = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bResp  = aebc_pkg::RESP_OKAY;
            if (regHit(awAddr_ff, aebc_pkg::AUX_ADDR)) begin
                // no bit-level update: only a full low byte lane writes
                if (wLow_ff) begin
                    nxt_aux = wData_ff & aebc_pkg::AUX_WMASK;
                end
            end else if (!regHit(awAddr_ff, aebc_pkg::STAT_ADDR)) begin
                nxt_bResp = aebc_pkg::RESP_SLVERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_bValid = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= 12'h000;
            wHeld_ff  <= 1'b0;
            wData_ff  <= 8'h00;
            wLow_ff   <= 1'b0;
            bValid_ff <= 1'b0;
            bResp_ff  <= aebc_pkg::RESP_OKAY;
            aux_ff    <= aebc_pkg::AUX_RESET;
        end else begin
            awHeld_ff <= nxt_awHeld;
            awAddr_ff <= nxt_awAddr;
            wHeld_ff  <= nxt_wHeld;
            wData_ff  <= nxt_wData;
            wLow_ff   <= nxt_wLow;
            bValid_ff <= nxt_bValid;
            bResp_ff  <= nxt_bResp;
            aux_ff    <= nxt_aux;
        end
    end

    assign statusWord = {27'h000_0000, !wrN_ff, !rdN_ff, aleOeN_ff, ale_ff, (state_ff != aebc_pkg::ST_IDLE)};

    // read channel; reserved bits 6 and 4 read as zero
    always_comb begin
        nxt_rValid = rValid_ff;
        nxt_rData  = rData_ff;
        nxt_rResp  = rResp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rValid = 1'b1;
            nxt_rResp  = aebc_pkg::RESP_OKAY;
            if (regHit(s_axi_araddr, aebc_pkg::AUX_ADDR)) begin
                nxt_rData = {24'h00_0000, aux_ff};
            end else if (regHit(s_axi_araddr, aebc_pkg::STAT_ADDR)) begin
                nxt_rData = statusWord;
            end else begin
                nxt_rData = 32'h0000_0000;
                nxt_rResp = aebc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            nxt_rValid = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rValid_ff <= 1'b0;
            rData_ff  <= 32'h0000_0000;
            rResp_ff  <= aebc_pkg::RESP_OKAY;
        end else begin
            rValid_ff <= nxt_rValid;
            rData_ff  <= nxt_rData;
            rResp_ff  <= nxt_rResp;
        end
    end

    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready  = !wHeld_ff && !bValid_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bResp_ff;
    assign s_axi_arready = !rValid_ff;
    assign s_axi_rvalid  = rValid_ff;
    assign s_axi_rdata   = rData_ff;
    assign s_axi_rresp   = rResp_ff;

    // bus-cycle sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_kind   = kind_ff;
        nxt_onchip = onchip_ff;
        tmrLoad    = 1'b0;
        tmrCount   = aebc_pkg::ALE_CYC;
        case (state_ff)
            aebc_pkg::ST_IDLE: begin
                if (reqValid) begin
                    nxt_kind   = reqKind;
                    nxt_onchip = isDataMove && routeOnchip;
                    if (isDataMove && routeOnchip) begin
                        nxt_state = aebc_pkg::ST_DONE;
                    end else if (reqKind == aebc_pkg::KIND_INTERNAL && suppress) begin
                        nxt_state = aebc_pkg::ST_DONE;
                    end else begin
                        // internal cycles strobe too unless suppressed
                        nxt_state = aebc_pkg::ST_ALE;
                        tmrLoad   = 1'b1;
                    end
                end
            end
            aebc_pkg::ST_ALE: begin
                if (tmrLast) begin
                    if (kind_ff == aebc_pkg::KIND_XREAD || kind_ff == aebc_pkg::KIND_XWRITE) begin
                        nxt_state = aebc_pkg::ST_STROBE;
                        tmrLoad   = 1'b1;
                        // stretch sampled at strobe start; a later write waits for the next move
                        tmrCount  = aux_ff[aebc_pkg::BIT_STRETCH] ? aebc_pkg::STROBE_LONG
                                                                  : aebc_pkg::STROBE_SHORT;
                    end else begin
                        nxt_state = aebc_pkg::ST_DONE;
                    end
                end
            end
            aebc_pkg::ST_STROBE: begin
                if (tmrLast) begin
                    nxt_state = aebc_pkg::ST_DONE;
                end
            end
            aebc_pkg::ST_DONE: begin
                nxt_state = aebc_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = aebc_pkg::ST_IDLE;
            end
        endcase
    end

    // pin values follow the next state so they line up with the phase
    always_comb begin
        nxt_ale    = (nxt_state == aebc_pkg::ST_ALE);
        // pin released whenever suppressed and no strobe is due
        nxt_aleOeN = suppress && (nxt_state != aebc_pkg::ST_ALE);
        nxt_rdN    = !(nxt_state == aebc_pkg::ST_STROBE && nxt_kind == aebc_pkg::KIND_XREAD);
        nxt_wrN    = !(nxt_state == aebc_pkg::ST_STROBE && nxt_kind == aebc_pkg::KIND_XWRITE);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff  <= aebc_pkg::ST_IDLE;
            kind_ff   <= aebc_pkg::KIND_INTERNAL;
            onchip_ff <= 1'b0;
            ale_ff    <= 1'b0;
            aleOeN_ff <= 1'b0;
            rdN_ff    <= 1'b1;
            wrN_ff    <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            kind_ff   <= nxt_kind;
            onchip_ff <= nxt_onchip;
            ale_ff    <= nxt_ale;
            aleOeN_ff <= nxt_aleOeN;
            rdN_ff    <= nxt_rdN;
            wrN_ff    <= nxt_wrN;
        end
    end

    assign reqReady      = (state_ff == aebc_pkg::ST_IDLE);
    assign doneValid     = (state_ff == aebc_pkg::ST_DONE);
    assign doneOnchip    = onchip_ff;
    assign aleOut        = ale_ff;
    assign aleOeN        = aleOeN_ff;
    assign alePullupEn   = aleOeN_ff;
    assign rdStrobeN     = rdN_ff;
    assign wrStrobeN     = wrN_ff;
    assign portPullupEn  = !aux_ff[aebc_pkg::BIT_PULLUP_DIS];
    assign offchipRamSel = aux_ff[aebc_pkg::BIT_OFFCHIP];

endmodule // aebc_top

// [tb/aebc_top_sva.sv]
module aebc_top_sva (
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    // bus-cycle request
    input wire logic                 reqValid,
    input wire aebc_pkg::aebc_kind_t reqKind,
    input wire logic                 reqReady,
    // pins and configuration
    input wire logic                 aleOut,
    input wire logic                 aleOeN,
    input wire logic                 alePullupEn,
    input wire logic                 rdStrobeN,
    input wire logic                 wrStrobeN,
    input wire logic [10:0]          xramBytes
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] lowCnt_ff;
    logic [5:0] nxt_lowCnt;
    logic       take;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    assign take = reqValid && reqReady;
    always_comb begin
        nxt_lowCnt = (!rdStrobeN || !wrStrobeN) ? lowCnt_ff + 6'h01 : 6'h00;
    end
    always_ff @(posedge core_clk) begin
        lowCnt_ff <= rst_n ? nxt_lowCnt : 6'h00;
    end
    // zero count means the strobe was cut by reset, not ended by the timer
    a_strobe_len: assert property ($rose(rdStrobeN && wrStrobeN) && lowCnt_ff != 6'h00 |->
        lowCnt_ff inside {6'h06, 6'h1e}) else $error("strobe length wrong");
    a_ale_width: assert property ($rose(aleOut) |-> aleOut ##1 aleOut ##1 !aleOut)
        else $error("latch strobe width wrong");
    a_ale_driven: assert property (aleOut |-> !aleOeN)
        else $error("latch strobe not driven");
    a_pullup_pair: assert property (aleOeN |-> alePullupEn && !aleOut)
        else $error("released latch pin not pulled up");
    a_size_legal: assert property (xramBytes inside {11'h100, 11'h200, 11'h300, 11'h400})
        else $error("ram size illegal");
    a_ale_before: assert property ($fell(rdStrobeN && wrStrobeN) |-> $past(aleOut))
        else $error("data strobe without latch");
    a_ext_ale: assert property (take && reqKind inside {aebc_pkg::KIND_FETCH, aebc_pkg::KIND_CODE}
        |=> aleOut[*2]) else $error("fetch without latch");
    a_int_ale: assert property (take && reqKind == aebc_pkg::KIND_INTERNAL && !aleOeN |=> aleOut)
        else $error("internal cycle without latch");
    a_int_quiet: assert property (take && reqKind == aebc_pkg::KIND_INTERNAL && aleOeN |=> !aleOut[*2])
        else $error("suppressed latch emitted");
endmodule // aebc_top_sva

bind aebc_top aebc_top_sva i_aebc_top_sva (
    .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .reqKind(reqKind), .reqReady(reqReady),
    .aleOut(aleOut), .aleOeN(aleOeN), .alePullupEn(alePullupEn), .rdStrobeN(rdStrobeN),
    .wrStrobeN(wrStrobeN), .xramBytes(xramBytes)
);

// [tb/aebc_ext_mem.sv]
module aebc_ext_mem (
    // pins from the device
    input  wire logic core_clk,
    input  wire logic aleOut,
    input  wire logic aleOeN,
    input  wire logic alePullupEn,
    input  wire logic rdStrobeN,
    input  wire logic wrStrobeN,
    // observed pin level and history
    output logic       aleWire,
    output logic [5:0] lastLen,
    output logic       lastWr,
    output logic [7:0] aleCount
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt = 6'h00;
    logic       alePrev = 1'b0;
    // a released pin only reads high if the weak pull-up is really on
    assign aleWire = aleOeN ? (alePullupEn ? 1'b1 : 1'bz) : aleOut;
    initial begin
        lastLen = 6'h00;
        lastWr = 1'b0;
        aleCount = 8'h00;
    end
    always @(posedge core_clk) begin
        alePrev <= aleOut;
        if (aleOut === 1'b1 && alePrev === 1'b0) aleCount <= aleCount + 8'h01;
        if (rdStrobeN === 1'b0 || wrStrobeN === 1'b0) begin
            cnt <= cnt + 6'h01;
            lastWr <= !wrStrobeN;
        end else if (cnt != 6'h00) begin
            lastLen <= cnt;
            cnt <= 6'h00;
        end
    end
endmodule // aebc_ext_mem

// [tb/tb_aux_external_bus_control.sv]
module tb_aux_external_bus_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] AUX = aebc_pkg::AUX_ADDR;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awA = 12'h000, arA = 12'h000;
    logic [31:0] wD = 32'h0000_0000, rD;
    logic [3:0] wS = 4'h0;
    logic awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0, rqV = 1'b0;
    logic awR, wR, bV, arR, rV, rqRdy, doneV, doneOn, ale, aleOe, alePu, rdN, wrN, puEn, offSel;
    logic [1:0] bRsp, rRsp;
    logic [10:0] xBytes;
    aebc_pkg::aebc_kind_t rqK = aebc_pkg::KIND_INTERNAL;
    logic [15:0] rqA = 16'h0000;
    logic aleWire, lastWr;
    logic [5:0] lastLen;
    logic [7:0] aleCnt;
    int failures = 0, n_tests = 0, tick = 0;

    aebc_top i_aebc_top (
        .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
        .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp),
        .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
        .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rRdy),
        .reqValid(rqV), .reqKind(rqK), .reqAddr(rqA), .reqReady(rqRdy), .doneValid(doneV),
        .doneOnchip(doneOn), .aleOut(ale), .aleOeN(aleOe), .alePullupEn(alePu), .rdStrobeN(rdN),
        .wrStrobeN(wrN), .portPullupEn(puEn), .xramBytes(xBytes), .offchipRamSel(offSel)
    );
    aebc_ext_mem i_aebc_ext_mem (
        .core_clk(core_clk), .aleOut(ale), .aleOeN(aleOe), .alePullupEn(alePu), .rdStrobeN(rdN),
        .wrStrobeN(wrN), .aleWire(aleWire), .lastLen(lastLen), .lastWr(lastWr), .aleCount(aleCnt)
    );

    always #50 core_clk = ~core_clk;

    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // run is well under a thousand cycles; ceiling leaves ample slack
    always @(posedge core_clk) begin
        tick++;
        if (tick == 5000) begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge core_clk);
        awA <= a;
        wD <= {24'h00_0000, d};
        wS <= s;
        awV <= 1'b1;
        wV <= 1'b1;
        bRdy <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awV && awR) awV <= 1'b0;
            if (wV && wR) wV <= 1'b0;
        end while (bV !== 1'b1);
        r = bRsp;
        bRdy <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        arA <= a;
        arV <= 1'b1;
        rRdy <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arV && arR) arV <= 1'b0;
        end while (rV !== 1'b1);
        d = rD;
        r = rRsp;
        rRdy <= 1'b0;
    endtask

    task automatic setAux(input logic [7:0] d);
        logic [1:0] r;
        wr(AUX, d, 4'h1, r);
        chk(r, aebc_pkg::RESP_OKAY);
    endtask

    task automatic cyc(input aebc_pkg::aebc_kind_t k, input logic [15:0] a, output int n);
        @(posedge core_clk);
        rqV <= 1'b1;
        rqK <= k;
        rqA <= a;
        do @(posedge core_clk); while (rqRdy !== 1'b1);
        rqV <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (doneV !== 1'b1);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rd(AUX, d, r);
        chk(d, 32'h0000_000c);
        chk(puEn, 1'b1);
        chk(xBytes, 11'h400);
        chk(offSel, 1'b0);
    endtask

    task automatic t_fields();
        logic [7:0] v[4] = '{8'h80, 8'h06, 8'h09, 8'hae};
        logic [31:0] d;
        logic [1:0] r;
        foreach (v[i]) begin
            setAux(v[i]);
            rd(AUX, d, r);
            chk(d, {24'h00_0000, v[i]});
            chk(puEn, !v[i][7]);
            chk(xBytes, {1'b0, v[i][3:2], 8'h00} + 11'h100);
            chk(offSel, v[i][1]);
        end
        // a partial-lane write must not touch the byte
        wr(AUX, 8'h00, 4'he, r);
        rd(AUX, d, r);
        chk(d, 32'h0000_00ae);
        wr(12'h000, 8'h01, 4'h1, r);
        chk(r, aebc_pkg::RESP_SLVERR);
        rd(12'h000, d, r);
        chk(r, aebc_pkg::RESP_SLVERR);
    endtask

    task automatic t_moves();
        aebc_pkg::aebc_kind_t k[2] = '{aebc_pkg::KIND_XREAD, aebc_pkg::KIND_XWRITE};
        logic [7:0] c;
        int n;
        for (int s = 0; s < 2; s++) begin
            setAux(s ? 8'h23 : 8'h03);
            foreach (k[j]) begin
                c = aleCnt;
                cyc(k[j], 16'h0010, n);
                @(posedge core_clk);
                chk(n, s ? 33 : 9);
                chk(lastLen, s ? 6'h1e : 6'h06);
                chk(lastWr, j);
                chk(aleCnt, c + 8'h01);
            end
        end
    endtask

    task automatic t_latch();
        aebc_pkg::aebc_kind_t k[3] = '{aebc_pkg::KIND_INTERNAL, aebc_pkg::KIND_FETCH, aebc_pkg::KIND_CODE};
        logic [7:0] c;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        for (int s = 0; s < 2; s++) begin
            setAux(s[7:0]);
            @(posedge core_clk);
            // unsuppressed idle pin is driven low; only a released pin floats up
            chk(aleWire, s);
            chk(aleOe, s);
            rd(aebc_pkg::STAT_ADDR, d, r);
            chk(d, s ? 32'h0000_0004 : 32'h0000_0000);
            foreach (k[j]) begin
                c = aleCnt;
                cyc(k[j], 16'h0000, n);
                chk(n, (s && j == 0) ? 1 : 3);
                chk(aleCnt, (s && j == 0) ? c : c + 8'h01);
            end
        end
    endtask

    task automatic t_route();
        logic [7:0] v[4] = '{8'h00, 8'h00, 8'h02, 8'h0c};
        logic [15:0] a[4] = '{16'h00ff, 16'h0100, 16'h0010, 16'h03ff};
        logic on[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        int n;
        foreach (v[i]) begin
            setAux(v[i]);
            cyc(aebc_pkg::KIND_XREAD, a[i], n);
            chk(doneOn, on[i]);
            chk(n, on[i] ? 1 : 9);
        end
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_fields();
        t_moves();
        t_latch();
        t_route();
        final_report();
    end
endmodule // tb_aux_external_bus_control
